// file: core/tpc_top.sv
// tpc_top: timer channel status/control block with apb register access
// assumes: counter and value compare outside, giving CH_MATCH on CLK_SYS;
// CH_PIN asynchronous; pin output drivers outside use CH_PIN_FUNC_EN
//
// Local design decisions: register access over APB and the register addresses.

`timescale 1ns/1ps

module tpc_top (
    // clock and reset
    input  wire logic                        CLK_SYS,
    input  wire logic                        RST_N,
    // apb slave
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [tpc_pkg::ADDR_W-1:0]  PADDR,
    input  wire logic [31:0]                 PWDATA,
    output logic      [31:0]                 PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    // channel pins and counter matches
    input  wire logic [tpc_pkg::NUM_CH-1:0]  CH_PIN,
    input  wire logic [tpc_pkg::NUM_CH-1:0]  CH_MATCH,
    // channel state towards counter and pin logic
    output logic [tpc_pkg::NUM_CH-1:0]       CH_PIN_FUNC_EN,
    output logic [2*tpc_pkg::NUM_CH-1:0]     CH_MODE,
    output logic [tpc_pkg::NUM_CH-1:0]       CH_CAPTURE,
    output logic                             CENTER_ALIGN,
    // interrupts
    output logic [tpc_pkg::NUM_CH-1:0]       CH_IRQ,
    output logic                             IRQ
);

    localparam int N = tpc_pkg::NUM_CH;

    // apb phase decode
    logic           setup_ph;
    logic           access_ph;
    logic           wr_acc;
    logic           rd_setup;
    logic           hit_ctrl;
    logic           hit_stat;
    logic           hit_mask;
    logic           mapped;
    logic [N-1:0]   hit_ch;

    // per-channel collected signals
    logic [7:0]     csc_arr [N];
    logic [N-1:0]   ch_evt;
    logic [N-1:0]   ch_req;
    logic [N-1:0]   cap_edge;

    // module registers
    logic           cas_reg;
    logic           cas_next;
    logic [N-1:0]   status_reg;
    logic [N-1:0]   status_next;
    logic [N-1:0]   mask_reg;
    logic [N-1:0]   mask_next;
    logic [N-1:0]   stat_clr;
    logic [31:0]    prdata_reg;
    logic [31:0]    prdata_next;
    logic [31:0]    rdata_mux;

    // phase and address decode
    assign setup_ph  = PSEL & ~PENABLE;
    assign access_ph = PSEL & PENABLE;
    assign wr_acc    = access_ph & PWRITE;
    assign rd_setup  = setup_ph & ~PWRITE;
    assign hit_ctrl  = (PADDR == tpc_pkg::ADDR_CTRL);
    assign hit_stat  = (PADDR == tpc_pkg::ADDR_IRQ_STATUS);
    assign hit_mask  = (PADDR == tpc_pkg::ADDR_IRQ_MASK);
    assign mapped    = hit_ctrl | hit_stat | hit_mask | (|hit_ch);

    // zero wait states; unmapped addresses answer with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = access_ph & ~mapped;

    // one independent channel per loop pass
    generate
        for (genvar i = 0; i < N; i++) begin : g_ch
            tpc_chan_if u_if ();

            assign hit_ch[i] = (PADDR == tpc_pkg::ADDR_W'(
                                tpc_pkg::ADDR_CSC_BASE +
                                tpc_pkg::CSC_STRIDE * i));

            // pin synchroniser and edge detect
            tpc_pin_edge u_edge (
                .clk        (CLK_SYS),
                .rst_n      (RST_N),
                .pin        (CH_PIN[i]),
                .els        (u_if.els),
                .edge_pulse (cap_edge[i])
            );

            // strobes: read arms at setup, write acts at access
            assign u_if.wr_stb       = wr_acc & hit_ch[i];
            assign u_if.rd_stb       = rd_setup & hit_ch[i];
            assign u_if.wdata        = PWDATA[7:0];
            assign u_if.center_align = cas_reg;
            assign u_if.cap_edge     = cap_edge[i];
            assign u_if.match        = CH_MATCH[i];

            // channel state and flag
            tpc_channel u_ch (
                .clk   (CLK_SYS),
                .rst_n (RST_N),
                .bus   (u_if.chan)
            );

            assign csc_arr[i]         = u_if.csc;
            assign ch_evt[i]          = u_if.event_pulse;
            assign ch_req[i]          = u_if.irq_req;
            assign CH_PIN_FUNC_EN[i]  = u_if.pin_en;
            assign CH_CAPTURE[i]      = u_if.capture;
            assign CH_MODE[2*i +: 2]  = u_if.mode;
        end
    endgenerate

    // read data select
    always_comb begin
        rdata_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_mux[tpc_pkg::CTRL_CAS_BIT]     = cas_reg;
            rdata_mux[tpc_pkg::CTRL_REQ_LSB +: N] = ch_req;
        end
        if (hit_stat) begin
            rdata_mux[N-1:0] = status_reg;
        end
        if (hit_mask) begin
            rdata_mux[N-1:0] = mask_reg;
        end
        for (int k = 0; k < N; k++) begin
            if (hit_ch[k]) begin
                rdata_mux[7:0] = csc_arr[k];
            end
        end
    end

    // next state of module registers
    always_comb begin
        cas_next  = cas_reg;
        mask_next = mask_reg;
        stat_clr  = '0;
        if (wr_acc && hit_ctrl) begin
            cas_next = PWDATA[tpc_pkg::CTRL_CAS_BIT];
        end
        if (wr_acc && hit_mask) begin
            mask_next = PWDATA[N-1:0];
        end
        if (wr_acc && hit_stat) begin
            stat_clr = PWDATA[N-1:0];
        end
        // write-one-to-clear; a same-cycle event keeps its bit
        status_next = (status_reg & ~stat_clr) | ch_evt;
        prdata_next = prdata_reg;
        if (rd_setup) begin
            prdata_next = rdata_mux;
        end
    end

    // registers
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cas_reg    <= tpc_pkg::CAS_RESET;
            status_reg <= tpc_pkg::IRQ_RESET;
            mask_reg   <= tpc_pkg::IRQ_RESET;
            prdata_reg <= tpc_pkg::PRDATA_RESET;
        end else begin
            cas_reg    <= cas_next;
            status_reg <= status_next;
            mask_reg   <= mask_next;
            prdata_reg <= prdata_next;
        end
    end

    // outputs
    assign PRDATA       = prdata_reg;
    assign CENTER_ALIGN = cas_reg;
    assign CH_IRQ       = ch_req;
    assign IRQ          = |(status_reg & mask_reg);

endmodule

// file: core/tpc_pkg.sv
// tpc_pkg: constants and types of the timer channel status/control block
// assumes: one bus clock, apb register access with 32-bit data

package tpc_pkg;

    // channel count and apb address width
    localparam int NUM_CH = 2;
    localparam int ADDR_W = 8;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_CSC_BASE   = 8'h10;
    localparam logic [ADDR_W-1:0] CSC_STRIDE      = 8'h04;

    // module control register fields
    localparam int CTRL_CAS_BIT = 0;
    localparam int CTRL_REQ_LSB = 8;

    // channel_status_control fields
    localparam int CSC_FLAG_BIT = 7;
    localparam int CSC_IE_BIT   = 6;
    localparam int CSC_MSH_BIT  = 5;
    localparam int CSC_MSL_BIT  = 4;
    localparam int CSC_ELS_MSB  = 3;
    localparam int CSC_ELS_LSB  = 2;

    // edge_level_select bit meaning for capture
    localparam int ELS_RISE_BIT = 0;
    localparam int ELS_FALL_BIT = 1;
    localparam logic [1:0] ELS_OFF = 2'h0;

    // reset values
    localparam logic       CAS_RESET   = 1'h0;
    localparam logic       FLAG_RESET  = 1'h0;
    localparam logic       IE_RESET    = 1'h0;
    localparam logic       MS_RESET    = 1'h0;
    localparam logic [1:0] ELS_RESET   = 2'h0;
    localparam logic [1:0] FILL_RESET  = 2'h0;
    localparam logic [NUM_CH-1:0] IRQ_RESET = '0;
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

    // effective channel mode
    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_CENTER_PWM
    } tpc_mode_t;

    // flag clearing handshake
    typedef enum logic {
        CLR_IDLE,
        CLR_ARMED
    } tpc_clr_state_t;

endpackage

// file: core/tpc_chan_if.sv
// tpc_chan_if: signals between the register front end and one channel
// assumes: all signals on the bus clock

`timescale 1ns/1ps

interface tpc_chan_if;
    logic                wr_stb;       // write of this channel register
    logic                rd_stb;       // read of this channel register
    logic [7:0]          wdata;
    logic                center_align;
    logic                cap_edge;     // qualified pin edge
    logic                match;        // counter equals channel value
    logic [7:0]          csc;          // register read-back
    logic [1:0]          els;
    logic                irq_req;
    logic                event_pulse;
    logic                capture;
    logic                pin_en;
    tpc_pkg::tpc_mode_t  mode;

    // front end side
    modport host (
        output wr_stb, rd_stb, wdata, center_align, cap_edge, match,
        input  csc, els, irq_req, event_pulse, capture, pin_en, mode
    );

    // channel side
    modport chan (
        input  wr_stb, rd_stb, wdata, center_align, cap_edge, match,
        output csc, els, irq_req, event_pulse, capture, pin_en, mode
    );
endinterface

// file: core/tpc_pin_edge.sv
// tpc_pin_edge: synchronises one channel pin and detects selected edges
// assumes: pin is asynchronous to clk; els comes from clk-domain logic

`timescale 1ns/1ps

module tpc_pin_edge (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // pin and edge selection
    input  wire logic       pin,
    input  wire logic [1:0] els,
    // one-cycle edge strobe
    output logic            edge_pulse
);

    logic       sync1_reg;
    logic       sync1_next;
    logic       sync2_reg;
    logic       sync2_next;
    logic       prev_reg;
    logic       prev_next;
    logic [1:0] fill_reg;
    logic [1:0] fill_next;
    logic       pulse_reg;
    logic       pulse_next;

    // next state: sync pair, history, edge compare
    always_comb begin
        sync1_next = pin;
        sync2_next = sync1_reg;
        prev_next  = sync2_reg;
        fill_next  = {fill_reg[0], 1'b1};
        // no edge until sync2_reg holds a real pin sample
        pulse_next = fill_reg[1] &
                     ((els[tpc_pkg::ELS_RISE_BIT] & sync2_reg & ~prev_reg) |
                      (els[tpc_pkg::ELS_FALL_BIT] & ~sync2_reg & prev_reg));
    end

    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
            fill_reg  <= tpc_pkg::FILL_RESET;
            pulse_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg  <= prev_next;
            fill_reg  <= fill_next;
            pulse_reg <= pulse_next;
        end
    end

    assign edge_pulse = pulse_reg;

endmodule

// file: core/tpc_channel.sv
// tpc_channel: one channel's status/control register and event flag
// assumes: strobes from the apb front end, match from the counter logic

`timescale 1ns/1ps

module tpc_channel (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // front end
    tpc_chan_if.chan  bus
);

    logic                   flag_reg;
    logic                   flag_next;
    logic                   ie_reg;
    logic                   ie_next;
    logic                   msh_reg;
    logic                   msh_next;
    logic                   msl_reg;
    logic                   msl_next;
    logic [1:0]             els_reg;
    logic [1:0]             els_next;
    tpc_pkg::tpc_clr_state_t clr_reg;
    tpc_pkg::tpc_clr_state_t clr_next;
    tpc_pkg::tpc_mode_t     mode;
    logic                   evt;

    // effective mode: module-wide center select overrides
    always_comb begin
        if (bus.center_align) begin
            mode = tpc_pkg::MODE_CENTER_PWM;
        end else if (msh_reg) begin
            mode = tpc_pkg::MODE_EDGE_PWM;
        end else if (msl_reg) begin
            mode = tpc_pkg::MODE_COMPARE;
        end else begin
            mode = tpc_pkg::MODE_CAPTURE;
        end
    end

    // event source per mode
    always_comb begin
        case (mode)
            tpc_pkg::MODE_CAPTURE: begin
                // pin detached when edge_level_select is off
                evt = bus.cap_edge & (els_reg != tpc_pkg::ELS_OFF);
            end
            tpc_pkg::MODE_COMPARE,
            tpc_pkg::MODE_EDGE_PWM: begin
                evt = bus.match;
            end
            tpc_pkg::MODE_CENTER_PWM: begin
                evt = bus.match;
            end
            default: begin
                evt = 1'b0;
            end
        endcase
    end

    // next state: fields, flag and clearing handshake
    always_comb begin
        ie_next   = ie_reg;
        msh_next  = msh_reg;
        msl_next  = msl_reg;
        els_next  = els_reg;
        flag_next = flag_reg;
        clr_next  = clr_reg;
        if (bus.wr_stb) begin
            ie_next  = bus.wdata[tpc_pkg::CSC_IE_BIT];
            msh_next = bus.wdata[tpc_pkg::CSC_MSH_BIT];
            msl_next = bus.wdata[tpc_pkg::CSC_MSL_BIT];
            els_next = bus.wdata[tpc_pkg::CSC_ELS_MSB:tpc_pkg::CSC_ELS_LSB];
            // zero clears only after an armed read; one is ignored
            if (clr_reg == tpc_pkg::CLR_ARMED &&
                !bus.wdata[tpc_pkg::CSC_FLAG_BIT]) begin
                flag_next = 1'b0;
            end
            clr_next = tpc_pkg::CLR_IDLE;
        end else if (bus.rd_stb && flag_reg) begin
            clr_next = tpc_pkg::CLR_ARMED;
        end
        // new event wins and restarts the sequence
        if (evt) begin
            flag_next = 1'b1;
            clr_next  = tpc_pkg::CLR_IDLE;
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_reg <= tpc_pkg::FLAG_RESET;
            ie_reg   <= tpc_pkg::IE_RESET;
            msh_reg  <= tpc_pkg::MS_RESET;
            msl_reg  <= tpc_pkg::MS_RESET;
            els_reg  <= tpc_pkg::ELS_RESET;
            clr_reg  <= tpc_pkg::CLR_IDLE;
        end else begin
            flag_reg <= flag_next;
            ie_reg   <= ie_next;
            msh_reg  <= msh_next;
            msl_reg  <= msl_next;
            els_reg  <= els_next;
            clr_reg  <= clr_next;
        end
    end

    // outputs to the front end
    assign bus.csc         = {flag_reg, ie_reg, msh_reg, msl_reg,
                              els_reg, 2'b00};
    assign bus.els         = els_reg;
    assign bus.irq_req     = flag_reg & ie_reg;
    assign bus.event_pulse = evt;
    assign bus.capture     = evt & (mode == tpc_pkg::MODE_CAPTURE);
    assign bus.pin_en      = (els_reg != tpc_pkg::ELS_OFF);
    assign bus.mode        = mode;

endmodule

// file: sim/tpc_monitor.sv
// tpc_monitor: concurrent checks on the ports of tpc_top
// assumes: bound into tpc_top; zero-wait apb; channel 0 at ADDR_CSC_BASE

`timescale 1ns/1ps

module tpc_monitor (
    // clock and reset
    input  wire logic                       CLK_SYS,
    input  wire logic                       RST_N,
    // apb slave side
    input  wire logic                       PSEL,
    input  wire logic                       PENABLE,
    input  wire logic                       PWRITE,
    input  wire logic [tpc_pkg::ADDR_W-1:0] PADDR,
    input  wire logic [31:0]                PWDATA,
    input  wire logic                       PSLVERR,
    // channel side
    input  wire logic [tpc_pkg::NUM_CH-1:0] CH_MATCH,
    input  wire logic [tpc_pkg::NUM_CH-1:0] CH_PIN_FUNC_EN,
    input  wire logic [3:0]                 CH_MODE,
    input  wire logic                       CENTER_ALIGN,
    input  wire logic [tpc_pkg::NUM_CH-1:0] CH_IRQ,
    input  wire logic                       IRQ
);
    // access phase of a write to channel 0's register
    logic wr_csc0;
    logic wr_any;
    assign wr_any  = PSEL && PENABLE && PWRITE;
    assign wr_csc0 = wr_any && PADDR == tpc_pkg::ADDR_CSC_BASE;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    // everything idle right after reset
    a_reset_clears_all: assert property (
        $rose(RST_N) |-> CH_IRQ == '0 && !IRQ && CH_MODE == 4'h0
            && !CENTER_ALIGN)
        else $error("outputs not cleared after reset");
    // request only drops on a write to the channel register
    a_flag_holds: assert property (
        $fell(CH_IRQ[0]) |-> $past(wr_csc0))
        else $error("channel request dropped without a write");
    // event during the clearing write keeps the flag
    a_event_restarts: assert property (
        wr_csc0 && PWDATA[6] && PWDATA[5:4] != 2'h0 && CH_MATCH[0]
            && CH_MODE[1:0] != 2'h0 && CH_IRQ[0] |=> CH_IRQ[0])
        else $error("flag lost to an event in the clearing write");
    a_center_forces: assert property (
        CENTER_ALIGN && $past(CENTER_ALIGN) |-> CH_MODE == 4'hf)
        else $error("center select did not force center pwm");
    a_mode_decode: assert property (
        wr_csc0 && !CENTER_ALIGN |=> CH_MODE[1:0] ==
            ($past(PWDATA[5]) ? 2'h2 : {1'b0, $past(PWDATA[4])}))
        else $error("mode select decode wrong");
    a_pin_release: assert property (
        wr_csc0 |=> CH_PIN_FUNC_EN[0] == ($past(PWDATA[3:2]) != 2'h0))
        else $error("pin function enable wrong");
    a_other_chan: assert property (
        wr_csc0 && !CENTER_ALIGN |=> $stable(CH_MODE[3:2]))
        else $error("channel 1 mode moved on channel 0 write");
    // sticky interrupt only falls through a write
    a_irq_sticky: assert property (
        IRQ && !wr_any |=> IRQ)
        else $error("interrupt dropped without a write");
    a_unmapped_err: assert property (
        PSEL && PENABLE && PADDR == 8'h0c |-> PSLVERR)
        else $error("no error on unmapped access");

    // main scenarios reached
    c_event_write: cover property (wr_csc0 && CH_MATCH[0]);
    c_center_match: cover property (CENTER_ALIGN && CH_MATCH[1]);
    c_flag_clear: cover property ($fell(CH_IRQ[0]));
endmodule

// file: sim/test_timer_channel_status_control.sv
// test_timer_channel_status_control: apb sequences with expected values
// assumes: tpc_top with pready tied high; match pulses on CLK_SYS

`timescale 1ns/1ps

`define CHK(n, e, a) \
    begin \
        comparisons++; \
        if ((a) !== (e)) begin \
            miscompares++; \
            $display("[FAIL] %s exp %h got %h", n, e, a); \
        end \
    end

module test_timer_channel_status_control;
    // register addresses
    localparam logic [7:0] csc0 = tpc_pkg::ADDR_CSC_BASE;
    localparam logic [7:0] csc1 = csc0 + tpc_pkg::CSC_STRIDE;
    localparam logic [7:0] ctrl = tpc_pkg::ADDR_CTRL;
    localparam logic [7:0] stat = tpc_pkg::ADDR_IRQ_STATUS;
    localparam logic [7:0] mask = tpc_pkg::ADDR_IRQ_MASK;

    // bench signals
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, center, irq, err;
    logic [1:0]  pin = 2'h0, match = 2'h0, func_en, ch_irq, cap;
    logic [3:0]  mode;
    logic [3:0]  capn = 4'h0;
    int          miscompares = 0, comparisons = 0, cyc = 0;

    tpc_top dut_u (
        .CLK_SYS        (clk),
        .RST_N          (rst_n),
        .PSEL           (psel),
        .PENABLE        (penable),
        .PWRITE         (pwrite),
        .PADDR          (paddr),
        .PWDATA         (pwdata),
        .PRDATA         (prdata),
        .PREADY         (pready),
        .PSLVERR        (pslverr),
        .CH_PIN         (pin),
        .CH_MATCH       (match),
        .CH_PIN_FUNC_EN (func_en),
        .CH_MODE        (mode),
        .CH_CAPTURE     (cap),
        .CENTER_ALIGN   (center),
        .CH_IRQ         (ch_irq),
        .IRQ            (irq)
    );

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            miscompares++;
            close_out();
        end
    end

    // count capture strobes of both channels
    always @(posedge clk) begin
        capn <= capn + {3'h0, cap[0]} + {3'h0, cap[1]};
    end

    // verdict and end of run
    task automatic close_out();
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // one apb transfer; m drives the match inputs in the access phase
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [1:0] m);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        match <= m;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        match <= 2'h0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 2'h0);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 2'h0);
        `CHK($sformatf("reg %h", a), e, q);
    endtask

    // one-cycle counter match, then let the flag land
    task automatic pulse(input logic [1:0] m);
        match <= m;
        @(posedge clk);
        match <= 2'h0;
        repeat (2) @(posedge clk);
    endtask

    // pin change, then wait out synchroniser and edge logic
    task automatic setpin(input logic [1:0] p);
        pin <= p;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset values of all registers
        for (int i = 0; i < 5; i++)
            rdc(8'((i < 3) ? 4 * i : 4 * i + 4), 32'h0);
        `CHK("irq", 1'b0, irq);
        `CHK("pready", 1'b1, pready);
        // every mode select pair, pin enabled
        for (int i = 0; i < 4; i++) begin
            wr(csc0, 32'h04 | (i << 4));
            `CHK("mode", (i[1] ? 4'h2 : {3'h0, i[0]}), mode);
            `CHK("pin en", 2'h1, func_en);
        end
        // flag write of one ignored, other bits read back
        wr(csc0, 32'hfc);
        rdc(csc0, 32'h7c);
        rdc(csc1, 32'h0);
        wr(csc0, 32'h50);
        `CHK("pin en", 2'h0, func_en);
        // compare match sets flag and channel request
        pulse(2'h1);
        `CHK("ch irq", 2'h1, ch_irq);
        `CHK("irq", 1'b0, irq);
        wr(csc0, 32'h50);
        rdc(csc0, 32'hd0);
        apb(1'b1, csc0, 32'h50, 2'h1);
        rdc(csc0, 32'hd0);
        wr(csc0, 32'h50);
        rdc(csc0, 32'h50);
        `CHK("ch irq", 2'h0, ch_irq);
        // enable off: flag without request
        wr(csc0, 32'h10);
        pulse(2'h1);
        `CHK("ch irq", 2'h0, ch_irq);
        rdc(csc0, 32'h90);
        wr(csc0, 32'h10);
        // sticky status, mask and block interrupt
        rdc(stat, 32'h1);
        wr(mask, 32'h1);
        rdc(mask, 32'h1);
        `CHK("slverr", 1'b0, err);
        `CHK("irq", 1'b1, irq);
        wr(stat, 32'h1);
        rdc(stat, 32'h0);
        `CHK("irq", 1'b0, irq);
        // center select overrides both channels
        wr(ctrl, 32'h1);
        `CHK("center", 5'h1f, {center, mode});
        rdc(ctrl, 32'h1);
        pulse(2'h2);
        rdc(csc1, 32'h80);
        pulse(2'h2);
        wr(csc1, 32'h0);
        rdc(csc1, 32'h80);
        wr(csc1, 32'h0);
        wr(ctrl, 32'h0);
        // capture on rising edge only; match ignored
        wr(csc1, 32'h04);
        pulse(2'h2);
        rdc(csc1, 32'h04);
        `CHK("capture", 4'h0, capn);
        setpin(2'h2);
        rdc(csc1, 32'h84);
        `CHK("capture", 4'h1, capn);
        wr(csc1, 32'h04);
        setpin(2'h0);
        rdc(csc1, 32'h04);
        `CHK("capture", 4'h1, capn);
        // released pin takes no edges
        wr(csc1, 32'h0);
        setpin(2'h2);
        rdc(csc1, 32'h0);
        `CHK("pin en", 2'h0, func_en);
        `CHK("capture", 4'h1, capn);
        // unmapped address
        apb(1'b1, 8'h0c, 32'hff, 2'h0);
        `CHK("slverr", 1'b1, err);
        apb(1'b0, 8'h0c, 32'h0, 2'h0);
        `CHK("slverr", 1'b1, err);
        `CHK("unmapped", 32'h0, q);
        close_out();
    end
endmodule

bind tpc_top tpc_monitor mon_u (
    .CLK_SYS,
    .RST_N,
    .PSEL,
    .PENABLE,
    .PWRITE,
    .PADDR,
    .PWDATA,
    .PSLVERR,
    .CH_MATCH,
    .CH_PIN_FUNC_EN,
    .CH_MODE,
    .CENTER_ALIGN,
    .CH_IRQ,
    .IRQ
);
